/* File: hdl/msec_exposure_regs.vh */
`ifndef MSEC_EXPOSURE_REGS_VH
`define MSEC_EXPOSURE_REGS_VH
// ----------------------------------------
// register word indices (byte address is index times four)
// ----------------------------------------
`define MSEC_CTRL 6'h00
`define MSEC_TIMING 6'h01
`define MSEC_DIV 6'h02
`define MSEC_SHUTTER 6'h03
`define MSEC_GAIN 6'h04
`define MSEC_EXPOSURE 6'h05
`define MSEC_BLACK 6'h06
`define MSEC_AE_RANGE 6'h07
`define MSEC_SH_RANGE 6'h08
`define MSEC_G_RANGE 6'h09
`define MSEC_ROI_POS 6'h0a
`define MSEC_ROI_SIZE 6'h0b
`define MSEC_SENSOR 6'h0c
`define MSEC_STATUS 6'h0d
// ----------------------------------------
// control field positions
// ----------------------------------------
`define MSEC_C_TRIG 0
`define MSEC_C_FR_EN 1
`define MSEC_C_XFER 2
`define MSEC_C_RANGE_LO 3
`define MSEC_C_ROI_LO 5
`define MSEC_C_AE_ON 7
`define MSEC_C_AE_FULL 8
`define MSEC_C_SH_AUTO 9
`define MSEC_C_G_AUTO 10
// ----------------------------------------
// reset values
// ----------------------------------------
`define MSEC_CTRL_RST 11'h006
`define MSEC_LINE_RST 16'h0064
`define MSEC_FLINES_RST 16'h0400
`define MSEC_DIV_RST 4'h1
`define MSEC_SH_RST 16'h0010
`define MSEC_IMGH_RST 16'h0200
`define MSEC_SENS_RST 6'h3f
// ----------------------------------------
// shutter presets (lines), gain and ae constants
// ----------------------------------------
`define MSEC_LIM_HWY 16'h0020
`define MSEC_LIM_CITY 16'h0040
`define MSEC_LIM_INDOOR 16'h0080
`define MSEC_LIM_LOWNOISE 16'h0400
`define MSEC_SH_EXT 16'hffff
`define MSEC_GAIN_MAX 8'hb4
`define MSEC_TGT18 10'h0b8
`define MSEC_AE_HYST 11'h008
`define MSEC_AE_SH_STEP 16'h0004
`define MSEC_AE_G_STEP 8'h02
`define MSEC_TOP_SENSOR 3'h5
`define MSEC_NUM_SENSORS 3'h6
`endif

/* File: hdl/msec_exposure_ctrl.v */
// Operation
// - all lines start and stop exposure together
// - staggered readout, one line period each
// - max shutter scales with frame divider
// - frame rate off extends max shutter
// - exposure ends evenly spaced across frames
// - free run reads out; trigger mode only clears while waiting
// - exposure continues while transfer disabled
// - free run applies shutter next frame
// - trigger mode applies shutter at trigger
// - four preset maximum shutter limits
// - user gain is variable stage, 0-18 dB
// - manual exposure uses written shutter, gain
// - auto parameters track programmed exposure value
// - full auto picks target, reports mean
// - controller touches only automatic parameters
// - lengthen shutter before raising gain
// - exposure value zero means 18% gray
// - ae target, shutter, gain held in ranges
// - statistics only inside region of interest
// - three metering presets over sensors
// - per-sensor auto exposure enable
// - brightness sets black level offset
`timescale 1ns/1ps
`include "msec_exposure_regs.vh"
module msec_exposure_ctrl (
	input wire hclk,
	input wire hresetn,
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output reg [31:0] hrdata,
	output reg hreadyout,
	output reg hresp,
	input wire trigger_in,
	input wire pix_valid,
	input wire [2:0] pix_sensor,
	input wire [15:0] pix_row,
	input wire [15:0] pix_col,
	input wire [9:0] pix_data,
	output reg exposing,
	output reg sensor_clear,
	output reg reading,
	output reg line_read,
	output reg [15:0] line_index,
	output reg frame_end,
	output reg xfer_active,
	output reg [15:0] shutter_out,
	output reg [7:0] gain_out,
	output reg [11:0] black_level
);
// ----------------------------------------
// helpers
// ----------------------------------------
function [15:0] clamp16;
	input [15:0] v;
	input [15:0] lo;
	input [15:0] hi;
	begin
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	end
endfunction
function [9:0] clamp10;
	input [10:0] v;
	input [9:0] lo;
	input [9:0] hi;
	begin
		clamp10 = (v < {1'b0, lo}) ? lo : ((v > {1'b0, hi}) ? hi : v[9:0]);
	end
endfunction
function [7:0] clamp8;
	input [7:0] v;
	input [7:0] lo;
	input [7:0] hi;
	begin
		clamp8 = (v < lo) ? lo : ((v > hi) ? hi : v);
	end
endfunction
localparam ST_FREE = 2'h0;
localparam ST_WAIT = 2'h1;
localparam ST_TEXP = 2'h2;
localparam ST_TRD = 2'h3;
// ----------------------------------------
// registers
// ----------------------------------------
reg [10:0] ctrl;
reg [15:0] line_cycles;
reg [15:0] frame_lines;
reg [3:0] frame_div;
reg [15:0] shutter_reg;
reg [7:0] gain_reg;
reg [9:0] ev_reg;
reg [9:0] ae_lo;
reg [9:0] ae_hi;
reg [15:0] sh_lo;
reg [15:0] sh_hi;
reg [7:0] g_lo;
reg [7:0] g_hi;
reg [15:0] roi_x;
reg [15:0] roi_y;
reg [15:0] roi_w;
reg [15:0] roi_h;
reg [5:0] sens_en;
reg [15:0] img_h;
reg [15:0] ae_sh;
reg [7:0] ae_g;
reg [9:0] mean;
wire trig_mode = ctrl[`MSEC_C_TRIG];
wire fr_en = ctrl[`MSEC_C_FR_EN];
wire xfer_en = ctrl[`MSEC_C_XFER];
wire [1:0] sh_range = ctrl[`MSEC_C_RANGE_LO+1:`MSEC_C_RANGE_LO];
wire [1:0] roi_preset = ctrl[`MSEC_C_ROI_LO+1:`MSEC_C_ROI_LO];
wire ae_on = ctrl[`MSEC_C_AE_ON];
wire sh_auto = ctrl[`MSEC_C_SH_AUTO];
wire g_auto = ctrl[`MSEC_C_G_AUTO];
wire ae_full = ctrl[`MSEC_C_AE_FULL] & sh_auto & g_auto;
wire ae_active = ae_on & (sh_auto | g_auto);
// ----------------------------------------
// shutter limits and commanded values
// ----------------------------------------
reg [15:0] preset_lim;
always @* begin
	case (sh_range)
		2'h0: preset_lim = `MSEC_LIM_HWY;
		2'h1: preset_lim = `MSEC_LIM_CITY;
		2'h2: preset_lim = `MSEC_LIM_INDOOR;
		default: preset_lim = `MSEC_LIM_LOWNOISE;
	endcase
end
wire [19:0] fmax = {4'h0, frame_lines} * {16'h0000, frame_div};
wire [15:0] fmax16 = (fmax[19:16] != 4'h0) ? 16'hffff : fmax[15:0];
wire [15:0] sh_max = fr_en ? clamp16(fmax16, 16'h0001, preset_lim) : `MSEC_SH_EXT;
wire [15:0] sh_cmd = clamp16((ae_active & sh_auto) ? ae_sh : shutter_reg, 16'h0001, sh_max);
wire [7:0] g_cmd = clamp8((ae_active & g_auto) ? ae_g : gain_reg, 8'h00, `MSEC_GAIN_MAX);
wire [19:0] sh_p1 = {4'h0, shutter_out} + 20'h00001;
wire [19:0] fl20 = {4'h0, frame_lines};
wire [19:0] frame_len = fr_en ? fmax : ((fl20 > sh_p1) ? fl20 : sh_p1);
// ----------------------------------------
// line and frame timing
// ----------------------------------------
reg [15:0] line_cnt;
reg [19:0] pos;
reg [15:0] exp_cnt;
reg [1:0] state;
// trigger accepted: line timing restarts so exposure is whole lines
wire trig_go = (state == ST_WAIT) && trig_mode && trigger_in;
wire [16:0] lc1 = {1'b0, line_cnt} + 17'h00001;
wire line_tick = lc1 >= {1'b0, line_cycles};
wire [19:0] pos1 = pos + 20'h00001;
wire wrap = pos1 >= frame_len;
wire [19:0] exp_start = frame_len - {4'h0, sh_cmd};
wire [19:0] exp_start_cur = frame_len - {4'h0, shutter_out};
wire [16:0] li1 = {1'b0, line_index} + 17'h00001;
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		line_cnt <= 16'h0000;
		pos <= 20'h00000;
		exp_cnt <= 16'h0000;
		state <= ST_FREE;
		exposing <= 1'b0;
		sensor_clear <= 1'b0;
		reading <= 1'b0;
		line_read <= 1'b0;
		line_index <= 16'h0000;
		frame_end <= 1'b0;
		xfer_active <= 1'b0;
		shutter_out <= `MSEC_SH_RST;
		gain_out <= 8'h00;
	end else begin
		line_cnt <= (line_tick || trig_go) ? 16'h0000 : lc1[15:0];
		line_read <= 1'b0;
		frame_end <= 1'b0;
		xfer_active <= reading & xfer_en;
		sensor_clear <= (state == ST_WAIT) && !trig_go;
		if (reading && line_tick) begin
			if (li1 >= {1'b0, img_h}) begin
				reading <= 1'b0;
				frame_end <= 1'b1;
			end else begin
				line_index <= li1[15:0];
				line_read <= 1'b1;
			end
		end
		case (state)
			ST_FREE: begin
				if (trig_mode) begin
					// let a running readout finish before clearing
					if (!reading) begin
						state <= ST_WAIT;
					end
					exposing <= 1'b0;
				end else if (line_tick) begin
					if (wrap) begin
						pos <= 20'h00000;
						shutter_out <= sh_cmd;
						gain_out <= g_cmd;
						exposing <= (exp_start == 20'h00000);
						reading <= 1'b1;
						line_index <= 16'h0000;
						line_read <= 1'b1;
					end else begin
						pos <= pos1;
						exposing <= (pos1 >= exp_start_cur);
					end
				end
			end
			ST_WAIT: begin
				if (!trig_mode) begin
					state <= ST_FREE;
					pos <= 20'h00000;
				end else if (trigger_in) begin
					shutter_out <= sh_cmd;
					gain_out <= g_cmd;
					exp_cnt <= sh_cmd;
					exposing <= 1'b1;
					state <= ST_TEXP;
				end
			end
			ST_TEXP: begin
				if (line_tick) begin
					if (exp_cnt <= 16'h0001) begin
						exposing <= 1'b0;
						reading <= 1'b1;
						line_index <= 16'h0000;
						line_read <= 1'b1;
						state <= ST_TRD;
					end else begin
						exp_cnt <= exp_cnt - 16'h0001;
					end
				end
			end
			ST_TRD: begin
				if (!reading) begin
					state <= ST_WAIT;
				end
			end
			default: state <= ST_FREE;
		endcase
	end
end
// ----------------------------------------
// region of interest and statistics
// ----------------------------------------
wire roi_all = (roi_w == 16'h0000) || (roi_h == 16'h0000);
wire [16:0] roi_xe = {1'b0, roi_x} + {1'b0, roi_w};
wire [16:0] roi_ye = {1'b0, roi_y} + {1'b0, roi_h};
wire in_win = roi_all || (pix_col >= roi_x && {1'b0, pix_col} < roi_xe &&
	pix_row >= roi_y && {1'b0, pix_row} < roi_ye);
wire [15:0] half = {1'b0, img_h[15:1]};
wire is_top = (pix_sensor == `MSEC_TOP_SENSOR);
reg in_preset;
always @* begin
	case (roi_preset)
		2'h1: in_preset = !is_top && (pix_row >= half);
		2'h2: in_preset = is_top || (pix_row < half);
		default: in_preset = 1'b1;
	endcase
end
wire sens_ok = (pix_sensor < `MSEC_NUM_SENSORS) && sens_en[pix_sensor];
wire take = pix_valid && in_win && in_preset && sens_ok;
reg [31:0] sum;
reg [23:0] cnt;
reg [31:0] dv_rem;
reg [23:0] dv_den;
reg [3:0] dv_bit;
reg [9:0] dv_q;
reg dv_busy;
reg ae_go;
wire [33:0] dv_sh = {10'h000, dv_den} << dv_bit;
wire [33:0] dv_trial = {2'b00, dv_rem} - dv_sh;
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		sum <= 32'h00000000;
		cnt <= 24'h000000;
		dv_rem <= 32'h00000000;
		dv_den <= 24'h000000;
		dv_bit <= 4'h0;
		dv_q <= 10'h000;
		dv_busy <= 1'b0;
		ae_go <= 1'b0;
	end else begin
		ae_go <= 1'b0;
		if (frame_end) begin
			dv_rem <= sum;
			dv_den <= cnt;
			dv_bit <= 4'h9;
			dv_q <= 10'h000;
			dv_busy <= (cnt != 24'h000000);
			sum <= take ? {22'h000000, pix_data} : 32'h00000000;
			cnt <= take ? 24'h000001 : 24'h000000;
		end else begin
			if (take) begin
				sum <= sum + {22'h000000, pix_data};
				cnt <= cnt + 24'h000001;
			end
			if (dv_busy) begin
				if (!dv_trial[33]) begin
					dv_rem <= dv_trial[31:0];
					dv_q[dv_bit] <= 1'b1;
				end
				if (dv_bit == 4'h0) begin
					dv_busy <= 1'b0;
					ae_go <= 1'b1;
				end else begin
					dv_bit <= dv_bit - 4'h1;
				end
			end
		end
	end
end
// ----------------------------------------
// auto exposure controller
// ----------------------------------------
wire [10:0] ev_sum = {1'b0, `MSEC_TGT18} + {ev_reg[9], ev_reg};
wire ev_neg = ev_reg[9] && !ev_sum[10];
wire [10:0] ev_tgt = ev_neg ? 11'h000 : ((ev_sum > 11'h3ff) ? 11'h3ff : ev_sum);
wire [10:0] tgt_raw = ae_full ? {1'b0, `MSEC_TGT18} : ev_tgt;
wire [9:0] target = clamp10(tgt_raw, ae_lo, ae_hi);
wire [15:0] shi = clamp16(sh_hi, 16'h0001, sh_max);
wire [7:0] ghi = clamp8(g_hi, 8'h00, `MSEC_GAIN_MAX);
wire [10:0] m_hi = {1'b0, dv_q} + `MSEC_AE_HYST;
wire [10:0] t_hi = {1'b0, target} + `MSEC_AE_HYST;
wire [15:0] sh_up = clamp16(ae_sh + `MSEC_AE_SH_STEP, sh_lo, shi);
wire [15:0] sh_dn = (ae_sh > sh_lo + `MSEC_AE_SH_STEP) ? ae_sh - `MSEC_AE_SH_STEP : sh_lo;
wire [7:0] g_up = clamp8(ae_g + `MSEC_AE_G_STEP, g_lo, ghi);
wire [7:0] g_dn = (ae_g > g_lo + `MSEC_AE_G_STEP) ? ae_g - `MSEC_AE_G_STEP : g_lo;
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		ae_sh <= `MSEC_SH_RST;
		ae_g <= 8'h00;
		mean <= 10'h000;
	end else if (ae_go) begin
		mean <= dv_q;
		if (ae_active) begin
			if (m_hi < {1'b0, target}) begin
				if (sh_auto && ae_sh < shi) begin
					ae_sh <= sh_up;
				end else if (g_auto && ae_g < ghi) begin
					ae_g <= g_up;
				end
			end else if ({1'b0, dv_q} > t_hi) begin
				if (g_auto && ae_g > g_lo) begin
					ae_g <= g_dn;
				end else if (sh_auto && ae_sh > sh_lo) begin
					ae_sh <= sh_dn;
				end
			end
		end
	end
end
// ----------------------------------------
// ahb-lite slave
// ----------------------------------------
reg wr_pend;
reg rd_pend;
reg [5:0] wr_addr;
reg [5:0] rd_addr;
reg [31:0] rd_mux;
wire accept = hsel && hready && htrans[1];
always @* begin
	case (rd_addr)
		`MSEC_CTRL: rd_mux = {21'h000000, ctrl};
		`MSEC_TIMING: rd_mux = {frame_lines, line_cycles};
		`MSEC_DIV: rd_mux = {28'h0000000, frame_div};
		`MSEC_SHUTTER: rd_mux = {16'h0000, shutter_out};
		`MSEC_GAIN: rd_mux = {24'h000000, gain_out};
		`MSEC_EXPOSURE: rd_mux = {22'h000000, ae_full ? mean : ev_reg};
		`MSEC_BLACK: rd_mux = {20'h00000, black_level};
		`MSEC_AE_RANGE: rd_mux = {6'h00, ae_hi, 6'h00, ae_lo};
		`MSEC_SH_RANGE: rd_mux = {sh_hi, sh_lo};
		`MSEC_G_RANGE: rd_mux = {16'h0000, g_hi, g_lo};
		`MSEC_ROI_POS: rd_mux = {roi_y, roi_x};
		`MSEC_ROI_SIZE: rd_mux = {roi_h, roi_w};
		`MSEC_SENSOR: rd_mux = {img_h, 10'h000, sens_en};
		`MSEC_STATUS: rd_mux = {3'h0, sensor_clear, reading, exposing, mean, sh_max};
		default: rd_mux = 32'h00000000;
	endcase
end
always @(posedge hclk or negedge hresetn) begin
	if (!hresetn) begin
		hrdata <= 32'h00000000;
		hreadyout <= 1'b1;
		hresp <= 1'b0;
		wr_pend <= 1'b0;
		rd_pend <= 1'b0;
		wr_addr <= 6'h00;
		rd_addr <= 6'h00;
		ctrl <= `MSEC_CTRL_RST;
		line_cycles <= `MSEC_LINE_RST;
		frame_lines <= `MSEC_FLINES_RST;
		frame_div <= `MSEC_DIV_RST;
		shutter_reg <= `MSEC_SH_RST;
		gain_reg <= 8'h00;
		ev_reg <= 10'h000;
		black_level <= 12'h000;
		ae_lo <= 10'h000;
		ae_hi <= 10'h3ff;
		sh_lo <= 16'h0001;
		sh_hi <= 16'hffff;
		g_lo <= 8'h00;
		g_hi <= `MSEC_GAIN_MAX;
		roi_x <= 16'h0000;
		roi_y <= 16'h0000;
		roi_w <= 16'h0000;
		roi_h <= 16'h0000;
		sens_en <= `MSEC_SENS_RST;
		img_h <= `MSEC_IMGH_RST;
	end else begin
		hresp <= 1'b0;
		wr_pend <= accept && hwrite;
		if (accept) begin
			wr_addr <= haddr[7:2];
			rd_addr <= haddr[7:2];
		end
		if (accept && !hwrite) begin
			rd_pend <= 1'b1;
			hreadyout <= 1'b0;
		end else if (rd_pend) begin
			rd_pend <= 1'b0;
			hrdata <= rd_mux;
			hreadyout <= 1'b1;
		end
		if (wr_pend) begin
			case (wr_addr)
				`MSEC_CTRL: ctrl <= hwdata[10:0];
				`MSEC_TIMING: begin
					line_cycles <= hwdata[15:0];
					frame_lines <= hwdata[31:16];
				end
				`MSEC_DIV: frame_div <= (hwdata[3:0] == 4'h0) ? 4'h1 : hwdata[3:0];
				`MSEC_SHUTTER: shutter_reg <= hwdata[15:0];
				`MSEC_GAIN: gain_reg <= clamp8(hwdata[7:0], 8'h00, `MSEC_GAIN_MAX);
				`MSEC_EXPOSURE: ev_reg <= hwdata[9:0];
				`MSEC_BLACK: black_level <= hwdata[11:0];
				`MSEC_AE_RANGE: begin
					ae_lo <= hwdata[9:0];
					ae_hi <= hwdata[25:16];
				end
				`MSEC_SH_RANGE: begin
					sh_lo <= hwdata[15:0];
					sh_hi <= hwdata[31:16];
				end
				`MSEC_G_RANGE: begin
					g_lo <= hwdata[7:0];
					g_hi <= hwdata[15:8];
				end
				`MSEC_ROI_POS: begin
					roi_x <= hwdata[15:0];
					roi_y <= hwdata[31:16];
				end
				`MSEC_ROI_SIZE: begin
					roi_w <= hwdata[15:0];
					roi_h <= hwdata[31:16];
				end
				`MSEC_SENSOR: begin
					sens_en <= hwdata[5:0];
					img_h <= hwdata[31:16];
				end
				default: ;
			endcase
		end
	end
end
endmodule // msec_exposure_ctrl

/* File: testbench/msec_exposure_assertions.sv */
`timescale 1ns/1ps
`include "msec_exposure_regs.vh"
module msec_exposure_assertions (
	input logic hclk,
	input logic hresetn,
	input logic hsel,
	input logic [1:0] htrans,
	input logic hwrite,
	input logic hready,
	input logic hreadyout,
	input logic hresp,
	input logic trigger_in,
	input logic exposing,
	input logic sensor_clear,
	input logic reading,
	input logic line_read,
	input logic frame_end,
	input logic xfer_active,
	input logic [15:0] shutter_out,
	input logic [7:0] gain_out
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence s_rd_answer;
		!hreadyout ##1 hreadyout;
	endsequence
	a_read_wait_one: assert property (s_rd_taken |=> s_rd_answer) else $error("read data phase length wrong");
	a_write_no_wait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout) else $error("write stalled");
	a_resp_always_okay: assert property (hresp == 1'b0) else $error("response not okay");
	a_line_in_readout: assert property (line_read |-> reading && !$past(line_read)) else $error("line pulse outside readout");
	a_frame_end_after: assert property (frame_end |-> $past(reading) ##1 !frame_end) else $error("frame end misplaced");
	a_expose_steady_shutter: assert property (exposing && $past(exposing) |-> $stable(shutter_out)) else $error("shutter moved in exposure");
	a_shutter_apply_edge: assert property ($changed(shutter_out) |-> $fell(exposing) || $rose(exposing)) else $error("shutter applied off boundary");
	a_clear_idle: assert property (sensor_clear |-> !exposing && !reading) else $error("clear while busy");
	a_trig_start: assert property (sensor_clear && trigger_in |=> exposing) else $error("trigger not started");
	a_gain_limit: assert property (gain_out <= `MSEC_GAIN_MAX) else $error("gain above limit");
	a_xfer_follows_read: assert property (xfer_active |-> $past(reading)) else $error("transfer without readout");
endmodule // msec_exposure_assertions
bind msec_exposure_ctrl msec_exposure_assertions u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .trigger_in(trigger_in),
	.exposing(exposing), .sensor_clear(sensor_clear), .reading(reading), .line_read(line_read),
	.frame_end(frame_end), .xfer_active(xfer_active), .shutter_out(shutter_out), .gain_out(gain_out));

/* File: testbench/tb_multi_sensor_exposure_control.sv */
`timescale 1ns/1ps
`include "msec_exposure_regs.vh"
module tb_multi_sensor_exposure_control;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, trigger_in = 0, pix_valid = 0;
	logic [31:0] haddr = 0, hwdata = 0, rd;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2, pix_sensor = 0;
	logic [15:0] pix_row = 0, pix_col = 0;
	logic [9:0] pix_data = 0;
	wire [31:0] hrdata;
	wire hreadyout, hresp, hready, exposing, sensor_clear, reading, line_read, frame_end, xfer_active;
	wire [15:0] line_index, shutter_out;
	wire [7:0] gain_out;
	wire [11:0] black_level;
	int error_cnt = 0, tests_run = 0, c, k;
	logic [15:0] lim [4] = '{`MSEC_LIM_HWY, `MSEC_LIM_CITY, `MSEC_LIM_INDOOR, `MSEC_LIM_LOWNOISE};
	always #25 hclk = ~hclk;
	assign hready = hreadyout;
	msec_exposure_ctrl dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
		.hresp(hresp), .trigger_in(trigger_in), .pix_valid(pix_valid), .pix_sensor(pix_sensor), .pix_row(pix_row),
		.pix_col(pix_col), .pix_data(pix_data), .exposing(exposing), .sensor_clear(sensor_clear), .reading(reading),
		.line_read(line_read), .line_index(line_index), .frame_end(frame_end), .xfer_active(xfer_active),
		.shutter_out(shutter_out), .gain_out(gain_out), .black_level(black_level));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task summarize;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task guard(inout int n);
		n++;
		if (n > 4000) begin
			error_cnt++;
			$display("mismatch wait expected event seen none");
			summarize();
		end
	endtask
	function logic sig(input int sel);
		case (sel)
			0: sig = exposing;
			1: sig = frame_end;
			2: sig = sensor_clear;
			3: sig = reading;
			5: sig = xfer_active;
			default: sig = line_read;
		endcase
	endfunction
	task bus(input logic [5:0] idx, input logic w, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge hclk);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, idx, 2'h0};
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin guard(n); @(posedge hclk); end
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin guard(n); @(posedge hclk); end
		rd = hrdata;
	endtask
	task wr(input logic [5:0] idx, input logic [31:0] d);
		bus(idx, 1'b1, d);
	endtask
	task rdc(input string nm, input logic [5:0] idx, input logic [31:0] m, input logic [31:0] e);
		bus(idx, 1'b0, 32'h0);
		chk(nm, rd & m, e);
	endtask
	task waitv(input int sel, input logic v);
		int n;
		n = 0;
		@(posedge hclk);
		while (sig(sel) !== v) begin guard(n); @(posedge hclk); end
	endtask
	task hi_len(input int sel, output int cn);
		waitv(sel, 0);
		waitv(sel, 1);
		cn = 0;
		while (sig(sel) === 1'b1) begin guard(cn); @(posedge hclk); end
	endtask
	task gap(input int sel, output int cn);
		waitv(sel, 1);
		cn = 1;
		@(posedge hclk);
		while (sig(sel) !== 1'b1) begin guard(cn); @(posedge hclk); end
	endtask
	// counts cycles with sel high from one frame end to the next
	task per_frame(input int sel, output int cn);
		int n;
		waitv(1, 1);
		cn = 0;
		n = 0;
		@(posedge hclk);
		while (frame_end !== 1'b1) begin guard(n); cn += (sig(sel) === 1'b1); @(posedge hclk); end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_regs;
		rdc("ctrl", `MSEC_CTRL, 32'hffffffff, 32'h6);
		wr(6'h3f, 32'h5a5a5a5a);
		rdc("unmapped", 6'h3f, 32'hffffffff, 32'h0);
		for (int p = 0; p < 4; p++) begin
			wr(`MSEC_CTRL, 32'h6 | (p << 3));
			rdc("max_shutter", `MSEC_STATUS, 32'hffff, lim[p]);
		end
		wr(`MSEC_TIMING, {16'd40, 16'd20});
		wr(`MSEC_SENSOR, {16'd8, 16'h3f});
		wr(`MSEC_DIV, 32'h2);
		rdc("max_div2", `MSEC_STATUS, 32'hffff, 32'd80);
		wr(`MSEC_DIV, 32'h0);
		rdc("max_div0", `MSEC_STATUS, 32'hffff, 32'd40);
		wr(`MSEC_CTRL, 32'h1c);
		rdc("max_ext", `MSEC_STATUS, 32'hffff, 32'hffff);
		wr(`MSEC_CTRL, 32'h6);
		wr(`MSEC_DIV, 32'h1);
	endtask
	task t_frame;
		wr(`MSEC_SHUTTER, 32'd5);
		waitv(1, 1);
		waitv(1, 1);
		chk("shutter_out", shutter_out, 32'd5);
		hi_len(0, c);
		chk("expose_len", c, 32'd100);
		gap(1, c);
		chk("frame_period", c, 32'd800);
		waitv(1, 1);
		gap(4, c);
		chk("line_period", c, 32'd20);
		per_frame(4, c);
		chk("line_count", c, 32'd8);
		wr(`MSEC_GAIN, 32'hff);
		waitv(1, 1);
		waitv(1, 1);
		rdc("gain", `MSEC_GAIN, 32'hffffffff, {24'h0, `MSEC_GAIN_MAX});
		wr(`MSEC_BLACK, 32'habc);
		@(posedge hclk);
		chk("black", black_level, 32'habc);
		wr(`MSEC_GAIN, 32'h0);
	endtask
	task t_xfer;
		wr(`MSEC_CTRL, 32'h2);
		per_frame(5, c);
		chk("xfer_off", c, 32'h0);
		hi_len(0, c);
		chk("expose_off", c, 32'd100);
		wr(`MSEC_CTRL, 32'h6);
		per_frame(5, c);
		chk("xfer_on", c > 0, 32'h1);
	endtask
	task t_trig;
		wr(`MSEC_CTRL, 32'h7);
		waitv(2, 1);
		wr(`MSEC_SHUTTER, 32'd7);
		c = 0;
		for (k = 0; k < 300; k++) begin @(posedge hclk); c += (reading === 1'b1); end
		chk("trig_idle_read", c, 32'h0);
		trigger_in <= 1;
		@(posedge hclk);
		trigger_in <= 0;
		c = 0;
		waitv(0, 1);
		while (exposing === 1'b1) begin guard(c); @(posedge hclk); end
		chk("trig_expose", c, 32'd140);
		c = 0;
		k = 0;
		while (sensor_clear !== 1'b1) begin guard(k); c += (line_read === 1'b1); @(posedge hclk); end
		chk("trig_lines", c, 32'd8);
		wr(`MSEC_CTRL, 32'h6);
	endtask
	task t_ae;
		pix_valid <= 1;
		pix_data <= 10'd100;
		wr(`MSEC_AE_RANGE, 32'h03ff0000);
		wr(`MSEC_SH_RANGE, 32'hffff0001);
		wr(`MSEC_G_RANGE, 32'h0000b400);
		wr(`MSEC_SHUTTER, 32'd4);
		repeat (2) waitv(1, 1);
		wr(`MSEC_CTRL, 32'h786);
		repeat (3) waitv(1, 1);
		chk("sh_first", shutter_out > `MSEC_SH_RST, 32'h1);
		chk("gain_held", gain_out, 32'h0);
		rdc("mean", `MSEC_EXPOSURE, 32'h3ff, 32'd100);
		wr(`MSEC_G_RANGE, 32'h00000400);
		wr(`MSEC_CTRL, 32'h486);
		repeat (4) waitv(1, 1);
		chk("sh_manual", shutter_out, 32'd4);
		chk("gain_range", gain_out, 32'h4);
	endtask
	// pixels all carry one value, so the mean only moves when a frame counts
	task t_stats;
		wr(`MSEC_SENSOR, {16'd8, 16'h3e});
		waitv(1, 1);
		pix_data <= 10'd200;
		waitv(1, 1);
		rdc("mean_masked", `MSEC_STATUS, 32'h03ff0000, {6'h0, 10'd100, 16'h0});
		wr(`MSEC_ROI_POS, 32'h00000001);
		wr(`MSEC_ROI_SIZE, 32'h00010001);
		wr(`MSEC_SENSOR, {16'd8, 16'h3f});
		repeat (2) waitv(1, 1);
		rdc("mean_roi", `MSEC_STATUS, 32'h03ff0000, {6'h0, 10'd100, 16'h0});
		wr(`MSEC_ROI_SIZE, 32'h0);
		repeat (2) waitv(1, 1);
		rdc("mean_all", `MSEC_STATUS, 32'h03ff0000, {6'h0, 10'd200, 16'h0});
	endtask
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1;
		t_regs();
		t_frame();
		t_xfer();
		t_trig();
		t_ae();
		t_stats();
		summarize();
	end
endmodule // tb_multi_sensor_exposure_control
